// ==== core/idac_ctrl_pkg.sv ====
package idac_ctrl_pkg;

    // register indices on the plain port
    localparam logic [7:0] ADDR_DAC_CONTROL = 8'hb9;
    localparam logic [7:0] ADDR_DAC_HIGH    = 8'hba;
    localparam logic [7:0] ADDR_DAC_LOW     = 8'hbb;
    localparam logic [7:0] ADDR_REF_CONTROL = 8'hbc;
    localparam logic [7:0] ADDR_DAC_ACTIVE  = 8'hbd;
    localparam logic [7:0] ADDR_BIAS_STATUS = 8'hbe;

    // dac control register layout and reset
    localparam int         DAC_ENABLE_POS   = 7;
    localparam int         DAC_SOURCE_POS   = 4;
    localparam int         DAC_FS_POS       = 0;
    localparam logic [7:0] DAC_CONTROL_RST  = 8'h72;
    localparam logic [7:0] DAC_CONTROL_WMASK = 8'hf3;

    // reference control layout
    localparam int         REF_BUFFER_POS   = 0;
    localparam int         REF_BIAS_POS     = 1;
    localparam int         REF_SELECT_POS   = 3;
    localparam logic [7:0] REF_CONTROL_RST  = 8'h00;
    localparam logic [7:0] REF_CONTROL_WMASK = 8'h0b;

    // update source codes
    localparam logic [2:0] SRC_TIMER0  = 3'h0;
    localparam logic [2:0] SRC_TIMER1  = 3'h1;
    localparam logic [2:0] SRC_TIMER2  = 3'h2;
    localparam logic [2:0] SRC_TIMER3  = 3'h3;
    localparam logic [2:0] SRC_RISE    = 3'h4;
    localparam logic [2:0] SRC_FALL    = 3'h5;
    localparam logic [2:0] SRC_ANY     = 3'h6;
    localparam logic [2:0] SRC_WRITE_H = 3'h7;

    // full-scale current selections
    typedef enum logic [2:0] {
        FS_0P5MA = 3'b001,
        FS_1P0MA = 3'b010,
        FS_2P0MA = 3'b100
    } full_scale_type;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    // analog control outputs
    typedef struct packed {
        logic           dac_on;
        full_scale_type full_scale;
        logic [9:0]     code;
        logic           vdd_ref;
        logic           bias_on;
        logic           ref_drive;
    } analog_ctrl_type;

    // peripheral enables that consume bias
    typedef struct packed {
        logic adc;
        logic temp_sensor;
        logic oscillator;
    } bias_users_type;

endpackage

// ==== core/idac_trigger_select.sv ====
`timescale 1ns/10ps
module idac_trigger_select (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // event sources
    input  wire logic [3:0] i_timer_ovf,
    input  wire logic       i_convert_start_input,
    input  wire logic       i_high_write,
    input  wire logic [2:0] i_source,
    // result
    output logic            o_update
);
    import idac_ctrl_pkg::*;

    typedef struct packed {
        logic cnv_last;
    } trig_state_type;

    trig_state_type state;
    trig_state_type next_state;
    logic           rise;
    logic           fall;

    // edge detect on the convert-start input
    always_comb begin
        next_state          = state;
        next_state.cnv_last = i_convert_start_input;
        rise = i_convert_start_input & ~state.cnv_last;
        fall = ~i_convert_start_input & state.cnv_last;
        case (i_source)
            SRC_TIMER0:  o_update = i_timer_ovf[0];
            SRC_TIMER1:  o_update = i_timer_ovf[1];
            SRC_TIMER2:  o_update = i_timer_ovf[2];
            SRC_TIMER3:  o_update = i_timer_ovf[3];
            SRC_RISE:    o_update = rise;
            SRC_FALL:    o_update = fall;
            SRC_ANY:     o_update = rise | fall;
            SRC_WRITE_H: o_update = i_high_write;
            default:     o_update = 1'b0;
        endcase
    end

    // register the edge history
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ==== core/bias_request.sv ====
`timescale 1ns/10ps
module bias_request (
    // consumers
    input  wire logic                          i_dac_on,
    input  wire idac_ctrl_pkg::bias_users_type i_users,
    input  wire logic                          i_force,
    // result
    output logic                               o_bias_on
);
    import idac_ctrl_pkg::*;

    // any consumer or the force bit turns bias on
    assign o_bias_on = i_dac_on | i_users.adc | i_users.temp_sensor
                     | i_users.oscillator
                     | i_force;
endmodule

// ==== core/current_dac_update_and_vref_control.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module current_dac_update_and_vref_control (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    // register port
    input  wire idac_ctrl_pkg::bus_req_type    i_bus,
    output logic [7:0]                         o_rdata,
    // event and consumer inputs
    input  wire logic [3:0]                    i_timer_ovf,
    input  wire logic                          i_convert_start_input,
    input  wire idac_ctrl_pkg::bias_users_type i_bias_users,
    // analog controls
    output idac_ctrl_pkg::analog_ctrl_type     o_analog
);
    import idac_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0]      dac_control_reg;
        logic [7:0]      reference_control_reg;
        logic [1:0]      dac_data_high;
        logic [7:0]      dac_data_low;
        logic [9:0]      active_code;
        logic [7:0]      rdata;
        analog_ctrl_type analog;
    } top_state_type;

    top_state_type state;
    top_state_type next_state;
    logic          high_write;
    logic          update;
    logic          bias_on;
    logic          next_dac_on;

    // decode a full-scale field into its one-hot selection
    function automatic full_scale_type decode_fs(input logic [1:0] fs);
        if (fs[1]) begin
            decode_fs = FS_2P0MA;
        end else if (fs[0]) begin
            decode_fs = FS_1P0MA;
        end else begin
            decode_fs = FS_0P5MA;
        end
    endfunction

    // write strobe to the data high byte
    assign high_write  = i_bus.wr && (i_bus.addr == ADDR_DAC_HIGH);

    // enable as it will stand next cycle
    assign next_dac_on = next_state.dac_control_reg[DAC_ENABLE_POS];

    idac_trigger_select u_trigger (
        .i_clk                 (i_clk),
        .i_sys_rst             (i_sys_rst),
        .i_timer_ovf           (i_timer_ovf),
        .i_convert_start_input (i_convert_start_input),
        .i_high_write          (high_write),
        .i_source              (state.dac_control_reg[DAC_SOURCE_POS +: 3]),
        .o_update              (update)
    );

    bias_request u_bias (
        .i_dac_on  (next_dac_on),
        .i_users   (i_bias_users),
        .i_force   (next_state.reference_control_reg[REF_BIAS_POS]),
        .o_bias_on (bias_on)
    );

    // register writes, update transfer, readback
    always_comb begin
        next_state = state;
        if (i_bus.wr) begin
            case (i_bus.addr)
                ADDR_DAC_CONTROL: next_state.dac_control_reg =
                    i_bus.wdata & DAC_CONTROL_WMASK;
                ADDR_DAC_HIGH:    next_state.dac_data_high = i_bus.wdata[1:0];
                ADDR_DAC_LOW:     next_state.dac_data_low  = i_bus.wdata;
                ADDR_REF_CONTROL: next_state.reference_control_reg =
                    i_bus.wdata & REF_CONTROL_WMASK;
                default:          next_state = next_state;
            endcase
        end
        // transfer uses the high byte as written in this cycle
        if (update && state.dac_control_reg[DAC_ENABLE_POS]) begin
            next_state.active_code = {next_state.dac_data_high,
                                      next_state.dac_data_low};
        end
        next_state.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr)
                ADDR_DAC_CONTROL: next_state.rdata = state.dac_control_reg;
                ADDR_DAC_HIGH:    next_state.rdata = {6'h00, state.dac_data_high};
                ADDR_DAC_LOW:     next_state.rdata = state.dac_data_low;
                ADDR_REF_CONTROL: next_state.rdata = state.reference_control_reg;
                ADDR_DAC_ACTIVE:  next_state.rdata = state.active_code[9:2];
                ADDR_BIAS_STATUS: next_state.rdata = {7'h00, state.analog.bias_on};
                default:          next_state.rdata = 8'h00;
            endcase
        end
        next_state.analog.dac_on     = next_dac_on;
        next_state.analog.full_scale =
            decode_fs(next_state.dac_control_reg[DAC_FS_POS +: 2]);
        next_state.analog.code       = next_state.active_code;
        next_state.analog.vdd_ref    =
            next_state.reference_control_reg[REF_SELECT_POS];
        next_state.analog.bias_on    = bias_on;
        next_state.analog.ref_drive  =
            next_state.reference_control_reg[REF_BUFFER_POS];
    end

    // state register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state                       <= '0;
            state.dac_control_reg       <= DAC_CONTROL_RST;
            state.reference_control_reg <= REF_CONTROL_RST;
            state.analog.full_scale     <= FS_2P0MA;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata  = state.rdata;
    assign o_analog = state.analog;
endmodule

// ==== test/idac_ctrl_assertions.sv ====
`timescale 1ns/10ps
module idac_ctrl_assertions
    import idac_ctrl_pkg::*;
(
    // clock and reset
    input wire logic                           i_clk,
    input wire logic                           i_sys_rst,
    // register port
    input wire idac_ctrl_pkg::bus_req_type     i_bus,
    input wire logic [7:0]                     o_rdata,
    // events and consumers
    input wire logic [3:0]                     i_timer_ovf,
    input wire logic                           i_convert_start_input,
    input wire idac_ctrl_pkg::bias_users_type  i_bias_users,
    input wire idac_ctrl_pkg::analog_ctrl_type o_analog
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // decoded register writes
    logic wr_ctl;
    logic wr_ref;
    assign wr_ctl = i_bus.wr && i_bus.addr == ADDR_DAC_CONTROL;
    assign wr_ref = i_bus.wr && i_bus.addr == ADDR_REF_CONTROL;
    property p_en; wr_ctl |=> o_analog.dac_on == $past(i_bus.wdata[7]); endproperty
    a_en: assert property (p_en) else $error("enable wrong");
    property p_fs; wr_ctl |=> o_analog.full_scale == ($past(i_bus.wdata[1]) ? FS_2P0MA
        : $past(i_bus.wdata[0]) ? FS_1P0MA : FS_0P5MA); endproperty
    a_fs: assert property (p_fs) else $error("full scale wrong");
    property p_sel; wr_ref |=> o_analog.vdd_ref == $past(i_bus.wdata[3]); endproperty
    a_sel: assert property (p_sel) else $error("ref select wrong");
    property p_buf; wr_ref |=> o_analog.ref_drive == $past(i_bus.wdata[0]); endproperty
    a_buf: assert property (p_buf) else $error("ref drive wrong");
    property p_frc; wr_ref && i_bus.wdata[1] |=> o_analog.bias_on; endproperty
    a_frc: assert property (p_frc) else $error("bias force lost");
    property p_use; (|i_bias_users) |=> o_analog.bias_on; endproperty
    a_use: assert property (p_use) else $error("bias off with users");
    property p_dbias; o_analog.dac_on |-> o_analog.bias_on; endproperty
    a_dbias: assert property (p_dbias) else $error("bias off with dac");
    property p_hold; !o_analog.dac_on |=> $stable(o_analog.code); endproperty
    a_hold: assert property (p_hold) else $error("code moved while off");
    property p_rsv; i_bus.rd && i_bus.addr == ADDR_DAC_CONTROL |=> o_rdata[3:2] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("unused bits set");
    // main scenarios reached
    c_src7: cover property (wr_ctl && i_bus.wdata == 8'hf0);
    c_ovf: cover property (o_analog.dac_on && |i_timer_ovf);
    c_frc: cover property (wr_ref && i_bus.wdata[1]);
endmodule
bind current_dac_update_and_vref_control idac_ctrl_assertions u_chk (.i_clk, .i_sys_rst,
    .i_bus, .o_rdata, .i_timer_ovf, .i_convert_start_input, .i_bias_users, .o_analog);

// ==== test/tb_current_dac_update_and_vref_control.sv ====
`timescale 1ns/10ps
module tb_current_dac_update_and_vref_control import idac_ctrl_pkg::*;;
    // bench signals
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    bus_req_type     bus = '0;
    logic [7:0]      rdata;
    logic [3:0]      ovf = 4'h0;
    logic            cvst = 1'b0;
    bias_users_type  users = '0;
    analog_ctrl_type ana;
    logic [9:0]      exp_code;
    int              bad_count = 0;
    int              cmp_count = 0;
    int              cyc = 0;
    // design under test
    current_dac_update_and_vref_control uut (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus),
        .o_rdata(rdata), .i_timer_ovf(ovf), .i_convert_start_input(cvst),
        .i_bias_users(users), .o_analog(ana));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle strobes on the register port
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // let a pulse be taken, then settle
    task automatic tick();
        @(posedge clk);
        ovf <= 4'h0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_DAC_CONTROL, 8'h72);
        rd(ADDR_REF_CONTROL, 8'h00);
        chk(ana, {1'b0, FS_2P0MA, 10'h000, 3'h0});
        wr(ADDR_DAC_CONTROL, 8'hff);
        rd(ADDR_DAC_CONTROL, 8'hf3);
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_DAC_CONTROL, 8'h70 | f[7:0]);
            chk(ana.full_scale, f[1] ? FS_2P0MA : f[0] ? FS_1P0MA : FS_0P5MA);
        end
        wr(ADDR_DAC_LOW, 8'h55);
        wr(ADDR_DAC_HIGH, 8'h02);
        chk(ana.code, 10'h000);
        wr(ADDR_DAC_CONTROL, 8'hf0);
        chk({ana.dac_on, ana.bias_on}, 2'h3);
        wr(ADDR_DAC_LOW, 8'ha5);
        chk(ana.code, 10'h000);
        wr(ADDR_DAC_HIGH, 8'h03);
        chk(ana.code, 10'h3a5);
        rd(ADDR_DAC_ACTIVE, 8'he9);
        rd(ADDR_DAC_HIGH, 8'h03);
        rd(ADDR_DAC_LOW, 8'ha5);
        exp_code = 10'h3a5;
        // wrong timers first, then the chosen one
        for (int n = 0; n < 4; n++) begin
            wr(ADDR_DAC_CONTROL, {1'b1, n[2:0], 4'h0});
            wr(ADDR_DAC_LOW, 8'h10 + n[7:0]);
            @(posedge clk) ovf <= ~(4'h1 << n);
            tick();
            chk(ana.code, exp_code);
            @(posedge clk) ovf <= 4'h1 << n;
            tick();
            exp_code = {2'h3, 8'h10 + n[7:0]};
            chk(ana.code, exp_code);
        end
        // rise then fall under each edge source
        for (int s = 4; s < 7; s++) begin
            wr(ADDR_DAC_CONTROL, {1'b1, s[2:0], 4'h0});
            for (int e = 0; e < 2; e++) begin
                wr(ADDR_DAC_LOW, {s[3:0], e[3:0]});
                @(posedge clk) cvst <= ~cvst;
                tick();
                if (e == 0 ? s != 5 : s != 4) exp_code = {2'h3, s[3:0], e[3:0]};
                chk(ana.code, exp_code);
            end
        end
        wr(ADDR_DAC_CONTROL, 8'h70);
        wr(ADDR_DAC_HIGH, 8'h00);
        chk({ana.dac_on, ana.code}, {1'b0, exp_code});
        wr(ADDR_REF_CONTROL, 8'hff);
        chk({ana.vdd_ref, ana.bias_on, ana.ref_drive}, 3'h7);
        rd(ADDR_REF_CONTROL, 8'h0b);
        rd(ADDR_BIAS_STATUS, 8'h01);
        wr(ADDR_REF_CONTROL, 8'h00);
        chk({ana.vdd_ref, ana.bias_on, ana.ref_drive}, 3'h0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) users <= 3'h1 << k;
            tick();
            chk(ana.bias_on, 1'b1);
        end
        @(posedge clk) users <= '0;
        tick();
        chk(ana.bias_on, 1'b0);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        rd(ADDR_DAC_CONTROL, 8'h70);
        report_and_stop();
    end
endmodule
